/* rtl/termination_state_control.sv */
// Termination state selection and synchronous termination timing
//
// Function
// - Termination enabled when any field nonzero
// - Write termination regardless of pin level
// - Pin high turns on nominal termination
// - Priority: disable, write, nominal, park
// - Idle: nominal, else park, else high-Z
// - Park is default when nominal off
// - Read forces high-Z for a window
// - Write command activates write termination window
// - Nominal disabled powers down pin receiver
// - Read disable starts read latency minus 2/3
// - Window lasts half burst plus 2/3/4; read half burst set by fixed chop only
// - Synchronous timing while loop locked
// - Nominal follows pin after turn latencies
// - Pin latencies: write+additive+parity minus 2/3
// - Read off latency: column+additive+parity minus 2/3
// - Park returns after off latency plus 4..8
// - Pin ignored when nominal off or self refresh
// - Termination off during self refresh
`timescale 1ns/1ps
`default_nettype none

module termination_state_control (
	// Clock and reset
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	// Termination control pin
	input  wire logic                              terminationControlPin,
	// Commands
	input  wire logic                              writeCmd,
	input  wire logic                              readCmd,
	input  wire logic                              chopFourOtf,
	// Mode register fields
	input  wire logic                              modeRegWrite,
	input  wire logic [term_ctrl_pkg::FIELD_W-1:0] nominalTermination,
	input  wire logic [term_ctrl_pkg::FIELD_W-1:0] writeTermination,
	input  wire logic [term_ctrl_pkg::FIELD_W-1:0] parkTermination,
	input  wire logic [term_ctrl_pkg::LAT_W-1:0]   columnWriteLatency,
	input  wire logic [term_ctrl_pkg::LAT_W-1:0]   columnReadLatency,
	input  wire logic [term_ctrl_pkg::LAT_W-1:0]   additiveLatency,
	input  wire logic [term_ctrl_pkg::LAT_W-1:0]   parityLatency,
	input  wire logic                              twoCyclePreamble,
	input  wire logic                              writeCheckCode,
	input  wire logic                              chopFourFixed,
	// Device condition
	input  wire logic                              dllLocked,
	input  wire logic                              selfRefresh,
	// Termination outputs
	output term_ctrl_pkg::term_state_t             termState,
	output logic [term_ctrl_pkg::FIELD_W-1:0]      termValue,
	output logic                                   termEnabled,
	output logic                                   pinReceiverEnable,
	output logic                                   syncMode
);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [term_ctrl_pkg::LAT_W-1:0] subPre(
		input logic [term_ctrl_pkg::LAT_W-1:0] sum,
		input logic                            twoPre
	);
		logic [term_ctrl_pkg::LAT_W-1:0] sub;
		sub = twoPre ? term_ctrl_pkg::SUB_TWO_PRE : term_ctrl_pkg::SUB_ONE_PRE;
		subPre = (sum > sub) ? sum - sub : '0;
	endfunction

	function automatic logic [term_ctrl_pkg::LAT_W-1:0] toTap(
		input logic [term_ctrl_pkg::LAT_W-1:0] lat,
		input logic [term_ctrl_pkg::LAT_W-1:0] front
	);
		logic [term_ctrl_pkg::LAT_W-1:0] room;
		room = front + term_ctrl_pkg::MIN_TAP;
		toTap = (lat > room) ? lat - front : term_ctrl_pkg::MIN_TAP;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	logic pinMeta_r;
	logic pinSync_r;
	logic pinMeta_nxt;
	logic pinSync_nxt;

	always_comb begin
		pinMeta_nxt = terminationControlPin;
		pinSync_nxt = pinMeta_r;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinMeta_r <= 1'b0;
			pinSync_r <= 1'b0;
		end else begin
			pinMeta_r <= pinMeta_nxt;
			pinSync_r <= pinSync_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latency and window settings
	logic [term_ctrl_pkg::LAT_W-1:0] pinTap_r;
	logic [term_ctrl_pkg::LAT_W-1:0] writeTap_r;
	logic [term_ctrl_pkg::LAT_W-1:0] readTap_r;
	logic [term_ctrl_pkg::DUR_W-1:0] readExtra_r;
	logic [term_ctrl_pkg::DUR_W-1:0] writeExtra_r;
	logic [term_ctrl_pkg::LAT_W-1:0] pinTap_nxt;
	logic [term_ctrl_pkg::LAT_W-1:0] writeTap_nxt;
	logic [term_ctrl_pkg::LAT_W-1:0] readTap_nxt;
	logic [term_ctrl_pkg::DUR_W-1:0] readExtra_nxt;
	logic [term_ctrl_pkg::DUR_W-1:0] writeExtra_nxt;
	logic [term_ctrl_pkg::LAT_W-1:0] directLat;
	logic [term_ctrl_pkg::LAT_W-1:0] readOffLat;

	always_comb begin
		directLat  = subPre(columnWriteLatency + additiveLatency + parityLatency,
			twoCyclePreamble);
		readOffLat = subPre(columnReadLatency + additiveLatency + parityLatency,
			twoCyclePreamble);
		pinTap_nxt     = pinTap_r;
		writeTap_nxt   = writeTap_r;
		readTap_nxt    = readTap_r;
		readExtra_nxt  = readExtra_r;
		writeExtra_nxt = writeExtra_r;
		if (modeRegWrite) begin
			pinTap_nxt   = toTap(directLat, term_ctrl_pkg::SYNC_STAGES);
			writeTap_nxt = toTap(directLat, term_ctrl_pkg::STATE_STAGE);
			readTap_nxt  = toTap(readOffLat, term_ctrl_pkg::STATE_STAGE);
			readExtra_nxt  = term_ctrl_pkg::WINDOW_BASE
				+ {3'h0, twoCyclePreamble} + {3'h0, writeCheckCode};
			writeExtra_nxt = {3'h0, twoCyclePreamble} + {3'h0, writeCheckCode};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinTap_r     <= term_ctrl_pkg::TAP_RESET;
			writeTap_r   <= term_ctrl_pkg::TAP_RESET;
			readTap_r    <= term_ctrl_pkg::TAP_RESET;
			readExtra_r  <= term_ctrl_pkg::WINDOW_BASE;
			writeExtra_r <= term_ctrl_pkg::CNT_RESET;
		end else begin
			pinTap_r     <= pinTap_nxt;
			writeTap_r   <= writeTap_nxt;
			readTap_r    <= readTap_nxt;
			readExtra_r  <= readExtra_nxt;
			writeExtra_r <= writeExtra_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latency delay lines
	logic pinGated;
	logic nomDelayed;
	logic writeDelayed;
	logic readDelayed;
	logic writeChop;
	logic readChop;
	logic chopNow;

	assign chopNow  = chopFourFixed | chopFourOtf;
	assign pinGated = pinSync_r & pinReceiverEnable;

	latency_delay_line pinDelay (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dataIn  (pinGated),
		.tap     (pinTap_r),
		.dataOut (nomDelayed)
	);

	latency_delay_line writeDelay (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dataIn  (writeCmd),
		.tap     (writeTap_r),
		.dataOut (writeDelayed)
	);

	latency_delay_line writeChopDelay (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dataIn  (chopNow),
		.tap     (writeTap_r),
		.dataOut (writeChop)
	);

	latency_delay_line readDelay (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dataIn  (readCmd),
		.tap     (readTap_r),
		.dataOut (readDelayed)
	);

	latency_delay_line readChopDelay (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dataIn  (chopFourFixed),
		.tap     (readTap_r),
		.dataOut (readChop)
	);

	////////////////////////////////////////////////////////////////////////
	// Read and write windows
	logic [term_ctrl_pkg::DUR_W-1:0] readCnt_r;
	logic [term_ctrl_pkg::DUR_W-1:0] writeCnt_r;
	logic [term_ctrl_pkg::DUR_W-1:0] readCnt_nxt;
	logic [term_ctrl_pkg::DUR_W-1:0] writeCnt_nxt;
	logic [term_ctrl_pkg::DUR_W-1:0] readDur;
	logic [term_ctrl_pkg::DUR_W-1:0] writeDur;

	always_comb begin
		readDur  = (readChop ? term_ctrl_pkg::HALF_BURST_CHOP
			: term_ctrl_pkg::HALF_BURST_FULL) + readExtra_r;
		writeDur = (writeChop ? term_ctrl_pkg::WRITE_WIN_CHOP
			: term_ctrl_pkg::WRITE_WIN_FULL) + writeExtra_r;
		readCnt_nxt  = (readCnt_r != '0) ? readCnt_r - 4'h1 : '0;
		writeCnt_nxt = (writeCnt_r != '0) ? writeCnt_r - 4'h1 : '0;
		if (readDelayed)
			readCnt_nxt = readDur - 4'h1;
		if (writeDelayed)
			writeCnt_nxt = writeDur - 4'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			readCnt_r  <= term_ctrl_pkg::CNT_RESET;
			writeCnt_r <= term_ctrl_pkg::CNT_RESET;
		end else begin
			readCnt_r  <= readCnt_nxt;
			writeCnt_r <= writeCnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Termination state selection
	term_ctrl_pkg::term_state_t      state_r;
	term_ctrl_pkg::term_state_t      state_nxt;
	logic [term_ctrl_pkg::FIELD_W-1:0] value_r;
	logic [term_ctrl_pkg::FIELD_W-1:0] value_nxt;
	logic                              enabled_r;
	logic                              enabled_nxt;
	logic                              recv_r;
	logic                              recv_nxt;
	logic                              sync_r;
	logic                              sync_nxt;
	logic                              disableNow;
	logic                              writeNow;
	logic                              nominalNow;
	logic                              parkNow;

	always_comb begin
		disableNow = selfRefresh | readDelayed | (readCnt_r != '0);
		writeNow   = (writeTermination != term_ctrl_pkg::FIELD_DISABLED)
			& (writeDelayed | (writeCnt_r != '0));
		nominalNow = (nominalTermination != term_ctrl_pkg::FIELD_DISABLED)
			& nomDelayed & sync_r;
		parkNow    = parkTermination != term_ctrl_pkg::FIELD_DISABLED;
		state_nxt = term_ctrl_pkg::TERM_OFF;
		value_nxt = term_ctrl_pkg::FIELD_DISABLED;
		if (disableNow) begin
			state_nxt = term_ctrl_pkg::TERM_OFF;
		end else if (writeNow) begin
			state_nxt = term_ctrl_pkg::TERM_WRITE;
			value_nxt = writeTermination;
		end else if (nominalNow) begin
			state_nxt = term_ctrl_pkg::TERM_NOMINAL;
			value_nxt = nominalTermination;
		end else if (parkNow) begin
			state_nxt = term_ctrl_pkg::TERM_PARK;
			value_nxt = parkTermination;
		end
		enabled_nxt = (nominalTermination | writeTermination | parkTermination)
			!= term_ctrl_pkg::FIELD_DISABLED;
		recv_nxt = (nominalTermination != term_ctrl_pkg::FIELD_DISABLED)
			& ~selfRefresh;
		sync_nxt = dllLocked & ~selfRefresh;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r   <= term_ctrl_pkg::TERM_OFF;
			value_r   <= term_ctrl_pkg::FIELD_DISABLED;
			enabled_r <= 1'b0;
			recv_r    <= 1'b0;
			sync_r    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			value_r   <= value_nxt;
			enabled_r <= enabled_nxt;
			recv_r    <= recv_nxt;
			sync_r    <= sync_nxt;
		end
	end

	assign termState         = state_r;
	assign termValue         = value_r;
	assign termEnabled       = enabled_r;
	assign pinReceiverEnable = recv_r;
	assign syncMode          = sync_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence readStart;
		readDelayed;
	endsequence

	sequence offFourCycles;
		(state_r == term_ctrl_pkg::TERM_OFF) [*4];
	endsequence

	property readWindowHolds;
		@(posedge ref_clk) disable iff (rst) readStart |=> offFourCycles;
	endproperty

	read_window_a : assert property (readWindowHolds)
		else $error("read window shorter than four cycles");

	read_forces_off_a : assert property (@(posedge ref_clk) disable iff (rst)
		(readCnt_r != '0) |=> state_r == term_ctrl_pkg::TERM_OFF)
		else $error("read window did not force high-Z");

	write_priority_a : assert property (@(posedge ref_clk) disable iff (rst)
		(writeNow && !disableNow) |=> state_r == term_ctrl_pkg::TERM_WRITE
			&& value_r == $past(writeTermination))
		else $error("write termination not selected");

	nominal_on_a : assert property (@(posedge ref_clk) disable iff (rst)
		(nominalNow && !writeNow && !disableNow)
			|=> state_r == term_ctrl_pkg::TERM_NOMINAL)
		else $error("nominal termination not selected");

	park_default_a : assert property (@(posedge ref_clk) disable iff (rst)
		(!disableNow && !writeNow && !nominalNow && parkNow)
			|=> state_r == term_ctrl_pkg::TERM_PARK)
		else $error("park termination not selected");

	self_refresh_off_a : assert property (@(posedge ref_clk) disable iff (rst)
		selfRefresh ##1 selfRefresh |-> state_r == term_ctrl_pkg::TERM_OFF
			&& !pinReceiverEnable)
		else $error("termination active in self refresh");

	receiver_off_a : assert property (@(posedge ref_clk) disable iff (rst)
		$past(nominalTermination) == term_ctrl_pkg::FIELD_DISABLED
			|-> !pinReceiverEnable && state_r != term_ctrl_pkg::TERM_NOMINAL)
		else $error("pin receiver powered with nominal disabled");

	enable_mode_a : assert property (@(posedge ref_clk) disable iff (rst)
		(state_r != term_ctrl_pkg::TERM_OFF) |-> termEnabled || $past(termEnabled))
		else $error("termination active while disabled");

	latency_update_a : assert property (@(posedge ref_clk) disable iff (rst)
		modeRegWrite ##1 !modeRegWrite [*2] |-> $stable(readTap_r)
			&& readExtra_r >= term_ctrl_pkg::WINDOW_BASE)
		else $error("latency changed without mode register write");

endmodule // termination_state_control

`default_nettype wire

/* rtl/term_ctrl_pkg.sv */
// Shared constants and types for the termination state control
package term_ctrl_pkg;

	// Field and latency widths
	localparam int unsigned FIELD_W     = 3;
	localparam int unsigned LAT_W       = 7;
	localparam int unsigned DUR_W       = 4;
	localparam int unsigned DELAY_DEPTH = 128;

	// Field value meaning disabled
	localparam logic [FIELD_W-1:0] FIELD_DISABLED = 3'h0;

	// Preamble subtractions
	localparam logic [LAT_W-1:0] SUB_ONE_PRE = 7'h02;
	localparam logic [LAT_W-1:0] SUB_TWO_PRE = 7'h03;

	// Pin synchroniser depth and delay line floor
	localparam logic [LAT_W-1:0] SYNC_STAGES = 7'h02;
	localparam logic [LAT_W-1:0] STATE_STAGE = 7'h01;
	localparam logic [LAT_W-1:0] MIN_TAP     = 7'h02;

	// Window lengths
	localparam logic [DUR_W-1:0] HALF_BURST_CHOP = 4'h2;
	localparam logic [DUR_W-1:0] HALF_BURST_FULL = 4'h4;
	localparam logic [DUR_W-1:0] WINDOW_BASE     = 4'h2;
	localparam logic [DUR_W-1:0] WRITE_WIN_CHOP  = 4'h4;
	localparam logic [DUR_W-1:0] WRITE_WIN_FULL  = 4'h6;

	// Reset values
	localparam logic [LAT_W-1:0] TAP_RESET = 7'h02;
	localparam logic [DUR_W-1:0] CNT_RESET = 4'h0;

	typedef enum logic [1:0] {
		TERM_OFF,
		TERM_NOMINAL,
		TERM_WRITE,
		TERM_PARK
	} term_state_t;

endpackage

/* rtl/latency_delay_line.sv */
// Single-bit delay line with a selectable tap and registered output
`timescale 1ns/1ps
`default_nettype none

module latency_delay_line (
	// Clock and reset
	input  wire logic                            ref_clk,
	input  wire logic                            rst,
	// Data
	input  wire logic                            dataIn,
	input  wire logic [term_ctrl_pkg::LAT_W-1:0] tap,
	output logic                                 dataOut
);

	logic [term_ctrl_pkg::DELAY_DEPTH-1:0] shift_r;
	logic [term_ctrl_pkg::DELAY_DEPTH-1:0] shift_nxt;
	logic                                  dataOut_r;
	logic                                  dataOut_nxt;

	////////////////////////////////////////////////////////////////////////
	// Delay equals tap cycles, tap of two or more
	always_comb begin
		shift_nxt   = {shift_r[term_ctrl_pkg::DELAY_DEPTH-2:0], dataIn};
		dataOut_nxt = shift_r[tap - term_ctrl_pkg::MIN_TAP];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shift_r   <= '0;
			dataOut_r <= 1'b0;
		end else begin
			shift_r   <= shift_nxt;
			dataOut_r <= dataOut_nxt;
		end
	end

	assign dataOut = dataOut_r;

endmodule // latency_delay_line

`default_nettype wire

/* verification/term_ctrl_host_model.sv */
// Controller model driving commands and the termination control pin
`timescale 1ns/1ps
`default_nettype none

module term_ctrl_host_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Requests from the bench
	input  wire logic pinReq,
	input  wire logic issueWrite,
	input  wire logic issueRead,
	input  wire logic otfChop,
	// Burst settings
	input  wire logic chopFixed,
	input  wire logic twoPre,
	input  wire logic crc,
	// Toward the device
	output logic      terminationControlPin,
	output logic      writeCmd,
	output logic      readCmd,
	output logic      chopFourOtf
);

	logic [3:0] holdLeft_r;
	logic       pinSeen_r;
	logic [3:0] holdLen;

	////////////////////////////////////////////////////////////////
	// Minimum pin hold, lengthened for preamble and check code
	assign holdLen = ((chopFixed | otfChop) ? 4'h4 : 4'h6)
		+ {3'h0, twoPre} + {3'h0, crc};
	assign terminationControlPin = pinReq | (holdLeft_r != 4'h0);
	assign writeCmd = issueWrite;
	assign readCmd = issueRead;
	assign chopFourOtf = otfChop;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			holdLeft_r <= 4'h0;
			pinSeen_r <= 1'b0;
		end else begin
			pinSeen_r <= terminationControlPin;
			if (terminationControlPin && (!pinSeen_r || writeCmd)) begin
				holdLeft_r <= holdLen - 4'h1;
			end else if (holdLeft_r != 4'h0) begin
				holdLeft_r <= holdLeft_r - 4'h1;
			end
		end
	end

endmodule // term_ctrl_host_model

`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the termination state control
`timescale 1ns/1ps
`default_nettype none

module tb_top;

	localparam logic [1:0] stOff  = term_ctrl_pkg::TERM_OFF;
	localparam logic [1:0] stNom  = term_ctrl_pkg::TERM_NOMINAL;
	localparam logic [1:0] stWr   = term_ctrl_pkg::TERM_WRITE;
	localparam logic [1:0] stPark = term_ctrl_pkg::TERM_PARK;

	logic ref_clk = 1'b0;
	logic rst, pinReq, issueWrite, issueRead, otfChop, modeRegWrite;
	logic twoPre, crc, chopFixed, dllLocked, selfRefresh;
	logic [2:0] nomF, wrF, parkF, termValue;
	logic [6:0] column_write_latency, crl, al, pl;
	logic pin, wCmd, rCmd, otfOut, termEnabled, pinRx, syncMode;
	term_ctrl_pkg::term_state_t termState;
	int badCount, numChecks;

	term_ctrl_host_model u_term_ctrl_host_model (.ref_clk(ref_clk), .rst(rst),
		.pinReq(pinReq), .issueWrite(issueWrite), .issueRead(issueRead), .otfChop(otfChop),
		.chopFixed(chopFixed), .twoPre(twoPre), .crc(crc), .terminationControlPin(pin),
		.writeCmd(wCmd), .readCmd(rCmd), .chopFourOtf(otfOut));

	termination_state_control u_termination_state_control (.ref_clk(ref_clk), .rst(rst),
		.terminationControlPin(pin), .writeCmd(wCmd), .readCmd(rCmd), .chopFourOtf(otfOut),
		.modeRegWrite(modeRegWrite), .nominalTermination(nomF), .writeTermination(wrF),
		.parkTermination(parkF), .columnWriteLatency(column_write_latency), .columnReadLatency(crl),
		.additiveLatency(al), .parityLatency(pl), .twoCyclePreamble(twoPre),
		.writeCheckCode(crc), .chopFourFixed(chopFixed), .dllLocked(dllLocked),
		.selfRefresh(selfRefresh), .termState(termState), .termValue(termValue),
		.termEnabled(termEnabled), .pinReceiverEnable(pinRx), .syncMode(syncMode));

	////////////////////////////////////////////////////////////////
	// Helpers
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic ck(input logic [7:0] seen, input logic [7:0] expv, input string what);
		numChecks++;
		if (seen !== expv) begin
			badCount++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expv);
		end
	endtask

	task automatic ckBit(input logic seen, input logic expv, input string what);
		ck({7'h00, seen}, {7'h00, expv}, what);
	endtask

	task automatic ckSt(input logic [1:0] s, input logic [2:0] v);
		ck({6'h00, termState}, {6'h00, s}, "state");
		ck({5'h00, termValue}, {5'h00, v}, "value");
	endtask

	task automatic ckBg(input logic hi);
		if (hi) ckSt(stNom, nomF);
		else ckSt(stPark, parkF);
	endtask

	task automatic setMode(input logic [6:0] c, a, p, input logic pre, cr, ch);
		column_write_latency = c;
		crl = c + 7'h02;
		al = a;
		pl = p;
		twoPre = pre;
		crc = cr;
		chopFixed = ch;
		modeRegWrite = 1'b1;
		tick(1);
		modeRegWrite = 1'b0;
		tick(2);
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic testFields;
		setMode(7'h09, 7'h00, 7'h00, 1'b0, 1'b0, 1'b0);
		ckBit(termEnabled, 1'b1, "enabled");
		ckBit(pinRx, 1'b1, "receiver");
		ckBit(syncMode, 1'b1, "sync");
		ckSt(stPark, parkF);
		nomF = 3'h0;
		pinReq = 1'b1;
		tick(15);
		ckBit(pinRx, 1'b0, "receiver off");
		ckSt(stPark, parkF);
		parkF = 3'h0;
		tick(3);
		ckSt(stOff, 3'h0);
		ckBit(termEnabled, 1'b1, "write field only");
		wrF = 3'h0;
		tick(3);
		ckBit(termEnabled, 1'b0, "all off");
		nomF = 3'h2;
		parkF = 3'h4;
		wrF = 3'h1;
		tick(15);
		ckSt(stNom, nomF);
		selfRefresh = 1'b1;
		tick(3);
		ckSt(stOff, 3'h0);
		ckBit(pinRx, 1'b0, "receiver in refresh");
		ckBit(syncMode, 1'b0, "sync in refresh");
		selfRefresh = 1'b0;
		dllLocked = 1'b0;
		tick(15);
		ckBit(syncMode, 1'b0, "sync unlocked");
		ckSt(stPark, parkF);
		dllLocked = 1'b1;
		pinReq = 1'b0;
		tick(15);
		$display("test fields done");
	endtask

	task automatic testPin(input logic [6:0] c, a, p, input logic pre);
		int dl;
		setMode(c, a, p, pre, 1'b0, 1'b0);
		dl = c + a + p - 2 - pre;
		pinReq = 1'b1;
		tick(dl);
		ckSt(stPark, parkF);
		tick(1);
		ckSt(stNom, nomF);
		tick(2);
		pinReq = 1'b0;
		tick(dl);
		ckSt(stNom, nomF);
		tick(1);
		ckSt(stPark, parkF);
		tick(dl + 2);
		$display("test pin done, latency %0d", dl);
	endtask

	task automatic testRead(input logic pre, cr, ch, hi);
		int rl;
		int d;
		setMode(7'h09, 7'h00, 7'h00, pre, cr, ch);
		rl = 11 - 2 - pre;
		d = (ch ? 2 : 4) + 2 + pre + cr;
		pinReq = hi;
		tick(15);
		issueRead = 1'b1;
		tick(1);
		issueRead = 1'b0;
		tick(rl - 2);
		ckBg(hi);
		tick(1);
		ckSt(stOff, 3'h0);
		tick(d - 1);
		ckSt(stOff, 3'h0);
		tick(1);
		ckBg(hi);
		pinReq = 1'b0;
		tick(15);
		$display("test read done, start %0d length %0d", rl, d);
	endtask

	task automatic testWrite(input logic otf, hi, input logic [2:0] wf);
		int w;
		setMode(7'h09, 7'h00, 7'h00, 1'b0, 1'b0, 1'b0);
		wrF = wf;
		w = otf ? 4 : 6;
		pinReq = hi;
		tick(15);
		issueWrite = 1'b1;
		otfChop = otf;
		tick(1);
		issueWrite = 1'b0;
		otfChop = 1'b0;
		tick(5);
		ckBg(hi);
		tick(1);
		if (wf != 3'h0) ckSt(stWr, wf);
		else ckBg(hi);
		tick(w - 1);
		if (wf != 3'h0) ckSt(stWr, wf);
		tick(1);
		ckBg(hi);
		pinReq = 1'b0;
		wrF = 3'h1;
		tick(15);
		$display("test write done, field %0d", wf);
	endtask

	task automatic testOverlap;
		setMode(7'h09, 7'h00, 7'h00, 1'b0, 1'b0, 1'b0);
		issueRead = 1'b1;
		tick(1);
		issueRead = 1'b0;
		issueWrite = 1'b1;
		tick(1);
		issueWrite = 1'b0;
		tick(6);
		ckSt(stWr, wrF);
		tick(2);
		ckSt(stOff, 3'h0);
		tick(20);
		$display("test overlap done");
	endtask

	////////////////////////////////////////////////////////////////
	// Verdict, watchdog and main sequence
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#50000;
		badCount++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		giveVerdict();
	end

	initial begin
		{pinReq, issueWrite, issueRead, otfChop, modeRegWrite} = 5'h00;
		{twoPre, crc, chopFixed, selfRefresh} = 4'h0;
		{column_write_latency, crl, al, pl} = {7'h09, 7'h0B, 7'h00, 7'h00};
		{nomF, wrF, parkF} = {3'h2, 3'h1, 3'h4};
		dllLocked = 1'b1;
		badCount = 0;
		numChecks = 0;
		rst = 1'b1;
		tick(4);
		rst = 1'b0;
		tick(1);
		testFields();
		testPin(7'h09, 7'h00, 7'h00, 1'b0);
		testPin(7'h09, 7'h00, 7'h00, 1'b1);
		testPin(7'h0C, 7'h02, 7'h01, 1'b0);
		testRead(1'b0, 1'b0, 1'b0, 1'b0);
		testRead(1'b0, 1'b1, 1'b0, 1'b0);
		testRead(1'b1, 1'b0, 1'b0, 1'b0);
		testRead(1'b1, 1'b1, 1'b0, 1'b0);
		testRead(1'b0, 1'b0, 1'b1, 1'b0);
		testRead(1'b0, 1'b0, 1'b0, 1'b1);
		testWrite(1'b0, 1'b0, 3'h1);
		testWrite(1'b1, 1'b0, 3'h5);
		testWrite(1'b0, 1'b1, 3'h1);
		testWrite(1'b0, 1'b0, 3'h0);
		testOverlap();
		giveVerdict();
	end

endmodule // tb_top

`default_nettype wire
